// ---- codec_regs_pkg.sv ----
//------------------------------------------------------------
// codec register bank constants
//------------------------------------------------------------
// Purpose: offsets, resets and carriers of the register bank
// Assumes: register index = byte address / 4
// Notes: every register holds 9 data bits
package codec_regs_pkg;

	// register indices
	localparam logic [5:0] IDX_FRAC_LOW = 6'h00;
	localparam logic [5:0] IDX_FRAC_MID = 6'h01;
	localparam logic [5:0] IDX_FRAC_TOP = 6'h02;
	localparam logic [5:0] IDX_PLLA_DIV = 6'h03;
	localparam logic [5:0] IDX_TX_WLEN = 6'h23;
	localparam logic [5:0] IDX_RX_MODE = 6'h24;
	localparam logic [5:0] IDX_INT_MASK = 6'h25;
	localparam logic [5:0] IDX_OUTPUT_PIN_SELECT_1 = 6'h26;
	localparam logic [5:0] IDX_OUTPUT_PIN_SELECT_2 = 6'h27;
	localparam logic [5:0] IDX_OUTPUT_PIN_SELECT_3 = 6'h28;
	localparam logic [5:0] IDX_OUTPUT_PIN_SELECT_4 = 6'h29;
	localparam logic [5:0] IDX_RSVD = 6'h2A;
	localparam logic [5:0] IDX_INT_STAT = 6'h2B;
	localparam logic [5:0] IDX_RX_CHAN1 = 6'h2C;
	localparam logic [5:0] IDX_RX_CHAN2 = 6'h2D;
	localparam logic [5:0] IDX_RX_CHAN3 = 6'h2E;
	localparam logic [5:0] IDX_RX_CHAN4 = 6'h2F;
	localparam logic [5:0] IDX_RX_CHAN5 = 6'h30;
	localparam logic [5:0] IDX_RX_STAT = 6'h31;
	localparam logic [5:0] IDX_PWRDN1 = 6'h32;
	localparam logic [5:0] IDX_PWRDN2 = 6'h33;
	localparam logic [5:0] IDX_READBACK = 6'h34;
	localparam logic [5:0] IDX_SW_RESET = 6'h35;
	localparam logic [5:0] IDX_PLL_MODE = 6'h36;

	// reset values
	localparam logic [8:0] RST_FRAC_LOW = 9'h121;
	localparam logic [8:0] RST_FRAC_MID = 9'h17E;
	localparam logic [8:0] RST_FRAC_TOP = 9'h07D;
	localparam logic [8:0] RST_PLLA_DIV = 9'h010;
	localparam logic [8:0] RST_TX_WLEN = 9'h00B;
	localparam logic [8:0] RST_RX_MODE = 9'h039;
	localparam logic [8:0] RST_INT_MASK = 9'h000;
	localparam logic [8:0] RST_OUTPUT_PIN_SELECT_1 = 9'h010;
	localparam logic [8:0] RST_OUTPUT_PIN_SELECT_2 = 9'h032;
	localparam logic [8:0] RST_OUTPUT_PIN_SELECT_3 = 9'h054;
	localparam logic [8:0] RST_OUTPUT_PIN_SELECT_4 = 9'h076;
	localparam logic [8:0] RST_RSVD = 9'h098;
	localparam logic [8:0] RST_PWRDN1 = 9'h07E;
	localparam logic [8:0] RST_PWRDN2 = 9'h03E;
	localparam logic [8:0] RST_READBACK = 9'h000;
	localparam logic [8:0] RST_PLL_MODE = 9'h010;

	// field positions
	localparam int FRAC_TOP_MSB = 3;
	localparam int INT_LSB = 4;
	localparam int INT_MSB = 7;
	localparam int HALVER_BIT = 0;
	localparam int SCALER_BIT = 1;
	localparam int DIV_LSB = 3;
	localparam int DIV_MSB = 4;
	localparam int RXCLK_BIT = 0;
	localparam int B_HALVER_BIT = 1;
	localparam int B_SCALER_BIT = 2;
	localparam int RB_SEL_MSB = 2;
	localparam int RB_CONT_BIT = 3;
	localparam int RB_EN_BIT = 4;

	// integer ratio advisory range
	localparam logic [3:0] INT_MIN = 4'h5;
	localparam logic [3:0] INT_MAX = 4'hD;

	// read-only status carried in from the transceiver
	typedef struct packed {
		logic [8:0] int_status;
		logic [8:0] chan1;
		logic [8:0] chan2;
		logic [8:0] chan3;
		logic [8:0] chan4;
		logic [8:0] chan5;
		logic [8:0] rx_status;
	} status_t;

	// plain configuration words handed to the chip
	typedef struct packed {
		logic [8:0] tx_word_len;
		logic [8:0] rx_input_mode;
		logic [8:0] int_mask;
		logic [8:0] output_pin_select_1;
		logic [8:0] output_pin_select_2;
		logic [8:0] output_pin_select_3;
		logic [8:0] output_pin_select_4;
		logic [8:0] pwrdn1;
		logic [8:0] pwrdn2;
	} config_t;

endpackage : codec_regs_pkg

// ---- codec_register_map_pll_a_cfg.sv ----
//------------------------------------------------------------
// codec register bank with pll a configuration
//------------------------------------------------------------
// Purpose: apb register bank for the codec control block
// Assumes: status inputs come from logic on pclk
// Notes: zero wait states, read data captured in setup;
//        writes and software reset land on the access edge
`timescale 1ns/1ps

// Operation
// R1 - fraction is 22 bits over three registers
// R2 - software keeps integer ratio five to thirteen
// R3 - reads of index 0,1 give identity
// R4 - continuous readback disables identity readback
// R5 - read of index 2 gives revision
// R6 - halver bit divides oscillator by two
// R7 - receiver mode: both halver bits must match
// R8 - receiver mode: scaler picks 256 or 128fs
// R9 - readback register fields, reset to zero
// R10 - receiver mode: divider a automatic, b ignored
// R11 - software reset write restores writable defaults
// R12 - writes to status addresses are ignored
module codec_register_map_pll_a_cfg
	import codec_regs_pkg::*;
#(
	// identity values, arbitrary
	parameter logic [8:0] IDENT_LOW = 9'h0A5,
	parameter logic [8:0] IDENT_HIGH = 9'h05A,
	parameter logic [8:0] REVISION = 9'h003
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire status_t status,
	input wire logic [1:0] rx_auto_divider,
	output config_t cfg,
	output logic [21:0] pll_a_fraction,
	output logic [3:0] pll_a_integer,
	output logic pll_a_integer_out_of_range,
	output logic pll_a_input_halver,
	output logic pll_a_output_scaler,
	output logic [1:0] pll_a_output_divider,
	output logic pll_a_clock_256fs,
	output logic receiver_clock_mode,
	output logic pll_b_input_halver,
	output logic pll_b_output_scaler,
	output logic [1:0] pll_b_output_divider,
	output logic pll_b_post_used,
	output logic halver_mismatch,
	output logic readback_enable,
	output logic continuous_readback,
	output logic [2:0] readback_source_select
);

	//------------------------------------------------------------
	// helper functions
	//------------------------------------------------------------

	// default value of each entry; slots not listed default to zero
	function automatic logic [8:0] reset_value(input logic [5:0] i);
		logic [8:0] v;
		v = 9'h000;
		case (i)
			IDX_FRAC_LOW: v = RST_FRAC_LOW;
			IDX_FRAC_MID: v = RST_FRAC_MID;
			IDX_FRAC_TOP: v = RST_FRAC_TOP;
			IDX_PLLA_DIV: v = RST_PLLA_DIV;
			IDX_TX_WLEN: v = RST_TX_WLEN;
			IDX_RX_MODE: v = RST_RX_MODE;
			IDX_INT_MASK: v = RST_INT_MASK;
			IDX_OUTPUT_PIN_SELECT_1: v = RST_OUTPUT_PIN_SELECT_1;
			IDX_OUTPUT_PIN_SELECT_2: v = RST_OUTPUT_PIN_SELECT_2;
			IDX_OUTPUT_PIN_SELECT_3: v = RST_OUTPUT_PIN_SELECT_3;
			IDX_OUTPUT_PIN_SELECT_4: v = RST_OUTPUT_PIN_SELECT_4;
			IDX_RSVD: v = RST_RSVD;
			IDX_PWRDN1: v = RST_PWRDN1;
			IDX_PWRDN2: v = RST_PWRDN2;
			IDX_READBACK: v = RST_READBACK;
			IDX_PLL_MODE: v = RST_PLL_MODE;
			default: v = 9'h000;
		endcase
		return v;
	endfunction : reset_value

	// entries that software may write; status, reserved and reset
	// slots are left out so that writes to them fall away
	function automatic logic writable(input logic [5:0] i);
		logic w;
		w = 1'b0;
		if (i <= IDX_PLLA_DIV)
		begin
			w = 1'b1;
		end
		else if (i >= IDX_TX_WLEN && i <= IDX_OUTPUT_PIN_SELECT_4)
		begin
			w = 1'b1;
		end
		else if (i >= IDX_PWRDN1 && i <= IDX_READBACK)
		begin
			w = 1'b1;
		end
		else if (i == IDX_PLL_MODE)
		begin
			w = 1'b1;
		end
		return w;
	endfunction : writable

	//------------------------------------------------------------
	// bus decode
	//------------------------------------------------------------

	logic [5:0] idx;
	logic in_low;
	logic in_high;
	logic mapped;
	logic setup;
	logic access;
	logic wr_fire;
	logic sw_reset;
	logic [8:0] wdata9;
	logic rd_err;
	logic err_q;
	logic [8:0] rd_value;
	logic [8:0] rd_q;
	logic [8:0] next_rd;

	// address split and phase strobes
	assign idx = paddr[7:2];
	assign in_low = idx <= IDX_PLLA_DIV;
	assign in_high = idx >= IDX_TX_WLEN && idx <= IDX_PLL_MODE;
	assign mapped = in_low || in_high;
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_fire = access && pwrite && mapped;
	assign wdata9 = pwdata[8:0];
	assign rd_err = !mapped;

	// any write to the reset address restores defaults
	assign sw_reset = wr_fire && idx == IDX_SW_RESET; // R11

	// no wait states; an unmapped index is refused in the access phase
	// with the error captured during setup
	assign pready = 1'b1;
	assign pslverr = access && err_q;

	//------------------------------------------------------------
	// register storage
	//------------------------------------------------------------

	// every slot has one continuous driver: a flop group or a constant
	logic [8:0] bank [0:63];

	// one flop group per writable entry, constants elsewhere
	genvar g;
	generate
		for (g = 0; g < 64; g++)
		begin : gen_entry
			// default of this slot, fixed at elaboration
			localparam logic [8:0] DEF = reset_value(6'(g));

			if (writable(6'(g)))
			begin : gen_rw
				logic hit;
				logic [8:0] q;

				// write strobe decoded for this slot only
				assign hit = wr_fire && idx == 6'(g);

				// soft reset outranks a write in the same cycle
				always_ff @(posedge pclk or negedge presetn)
				begin
					if (!presetn)
						q <= DEF; // R9
					else if (sw_reset)
						q <= DEF; // R11
					else if (hit)
						q <= wdata9;
				end

				assign bank[g] = q;
			end
			else
			begin : gen_ro
				// status, reserved and reset slots hold no writes
				assign bank[g] = DEF; // R12
			end
		end
	endgenerate

	//------------------------------------------------------------
	// pll a fields
	//------------------------------------------------------------

	// the ratio words feed the pll as they stand; change them only while
	// the pll is powered down, as an update over three writes passes mixed values
	logic [8:0] frac_low;
	logic [8:0] frac_mid;
	logic [8:0] frac_top;
	logic [8:0] div_a;
	logic [8:0] pll_mode;
	logic [8:0] readback;

	assign frac_low = bank[IDX_FRAC_LOW];
	assign frac_mid = bank[IDX_FRAC_MID];
	assign frac_top = bank[IDX_FRAC_TOP];
	assign div_a = bank[IDX_PLLA_DIV];
	assign pll_mode = bank[IDX_PLL_MODE];
	assign readback = bank[IDX_READBACK];

	// 22 bit fraction: low, mid, then four top bits
	assign pll_a_fraction = {frac_top[FRAC_TOP_MSB:0], frac_mid, frac_low}; // R1

	// integer ratio and advisory range flag; the flag only reports,
	// the ratio is passed on as written
	assign pll_a_integer = frac_top[INT_MSB:INT_LSB];
	assign pll_a_integer_out_of_range = pll_a_integer < INT_MIN
		|| pll_a_integer > INT_MAX; // R2

	// input halver: 1 halves the oscillator clock
	assign pll_a_input_halver = div_a[HALVER_BIT]; // R6
	assign pll_a_output_scaler = div_a[SCALER_BIT];

	//------------------------------------------------------------
	// receiver clocking mode
	//------------------------------------------------------------

	// the pll mode slot is a local register holding the receiver clocking
	// select and the pll b fields that decide how pll a is set up
	assign receiver_clock_mode = pll_mode[RXCLK_BIT];
	assign pll_b_input_halver = pll_mode[B_HALVER_BIT];
	assign pll_b_output_scaler = pll_mode[B_SCALER_BIT];
	assign pll_b_output_divider = pll_mode[DIV_MSB:DIV_LSB];

	// divider a follows the receiver, b scaler and divider go unused;
	// the written divider a field still holds its value for user mode
	assign pll_a_output_divider = receiver_clock_mode
		? rx_auto_divider
		: div_a[DIV_MSB:DIV_LSB]; // R10
	assign pll_b_post_used = !receiver_clock_mode; // R10

	// scaler 0 gives 256fs, 1 gives 128fs in receiver mode
	assign pll_a_clock_256fs = receiver_clock_mode
		&& !pll_a_output_scaler; // R8

	// flags a halver setting that software must keep equal
	assign halver_mismatch = receiver_clock_mode
		&& (pll_a_input_halver != pll_b_input_halver); // R7

	//------------------------------------------------------------
	// readback control and config words
	//------------------------------------------------------------

	// readback control fields, all zero after either reset
	assign readback_enable = readback[RB_EN_BIT]; // R9
	assign continuous_readback = readback[RB_CONT_BIT]; // R9
	assign readback_source_select = readback[RB_SEL_MSB:0]; // R9

	// plain words handed on; their fields are decoded by their users
	assign cfg.tx_word_len = bank[IDX_TX_WLEN];
	assign cfg.rx_input_mode = bank[IDX_RX_MODE];
	assign cfg.int_mask = bank[IDX_INT_MASK];
	assign cfg.output_pin_select_1 = bank[IDX_OUTPUT_PIN_SELECT_1];
	assign cfg.output_pin_select_2 = bank[IDX_OUTPUT_PIN_SELECT_2];
	assign cfg.output_pin_select_3 = bank[IDX_OUTPUT_PIN_SELECT_3];
	assign cfg.output_pin_select_4 = bank[IDX_OUTPUT_PIN_SELECT_4];
	assign cfg.pwrdn1 = bank[IDX_PWRDN1];
	assign cfg.pwrdn2 = bank[IDX_PWRDN2];

	//------------------------------------------------------------
	// read selection
	//------------------------------------------------------------

	logic ident_ok;
	logic sel_ident_low;
	logic sel_ident_high;
	logic sel_revision;
	logic sel_status;
	logic sel_reset_slot;
	logic [8:0] status_value;
	logic [8:0] low_value;

	// identity only when continuous readback is off
	assign ident_ok = !continuous_readback; // R4

	// which fixed word, if any, replaces the stored value
	assign sel_ident_low = idx == IDX_FRAC_LOW && ident_ok; // R3
	assign sel_ident_high = idx == IDX_FRAC_MID && ident_ok; // R3
	assign sel_revision = idx == IDX_FRAC_TOP; // R5
	assign sel_status = idx >= IDX_INT_STAT && idx <= IDX_RX_STAT;
	assign sel_reset_slot = idx == IDX_SW_RESET;

	// identity, revision or stored value for the low block;
	// written low and mid fraction words stay readable only in continuous mode
	assign low_value = sel_ident_low ? IDENT_LOW // R3
		: sel_ident_high ? IDENT_HIGH // R3
		: sel_revision ? REVISION // R5
		: bank[idx];

	// live status words, one slot per field in address order
	assign status_value = (idx == IDX_INT_STAT) ? status.int_status
		: (idx == IDX_RX_CHAN1) ? status.chan1
		: (idx == IDX_RX_CHAN2) ? status.chan2
		: (idx == IDX_RX_CHAN3) ? status.chan3
		: (idx == IDX_RX_CHAN4) ? status.chan4
		: (idx == IDX_RX_CHAN5) ? status.chan5
		: status.rx_status;

	// final read value; reset slot reads zero
	assign rd_value = in_low ? low_value
		: sel_status ? status_value
		: sel_reset_slot ? 9'h000 // R11
		: in_high ? bank[idx]
		: 9'h000;

	//------------------------------------------------------------
	// read data and error capture
	//------------------------------------------------------------

	// writes return zero data
	assign next_rd = pwrite ? 9'h000 : rd_value;

	// capture in setup so the access phase presents flopped data; live
	// status is sampled once here, so it cannot change under the master
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_q <= 9'h000;
			err_q <= 1'b0;
		end
		else if (setup)
		begin
			rd_q <= next_rd;
			err_q <= rd_err;
		end
	end

	assign prdata = {23'h000000, rd_q};

endmodule : codec_register_map_pll_a_cfg

// ---- codec_register_map_pll_a_cfg_props.sv ----
// Purpose: port assertions for the codec register bank
// Assumes: apb master holds each request until pready
// Notes: identity values arrive as parameters
`timescale 1ns/1ps
//------------------------------------------------------------
// checker
//------------------------------------------------------------
module codec_register_map_pll_a_cfg_props #(
	parameter logic [8:0] IDENT_LOW = 9'h0A5,
	parameter logic [8:0] REVISION = 9'h003
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] rx_auto_divider,
	input wire logic [21:0] pll_a_fraction,
	input wire logic pll_a_input_halver,
	input wire logic pll_a_output_scaler,
	input wire logic [1:0] pll_a_output_divider,
	input wire logic pll_a_clock_256fs,
	input wire logic receiver_clock_mode,
	input wire logic pll_b_input_halver,
	input wire logic halver_mismatch,
	input wire logic readback_enable,
	input wire logic continuous_readback,
	input wire logic [2:0] readback_source_select
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// read setup then its access cycle
	sequence s_rd(logic [5:0] i);
		psel && !penable && !pwrite && paddr[7:2] == i ##1 psel && penable;
	endsequence
	// completed write to one index
	sequence s_wr(logic [5:0] i);
		psel && penable && pwrite && pready && paddr[7:2] == i;
	endsequence
	a_ident_low: assert property (s_rd(6'h00) ##0 !continuous_readback |->
		prdata == {23'h0, IDENT_LOW}) else $error("identity read wrong");
	a_cont_stored: assert property (s_rd(6'h00) ##0 continuous_readback |->
		prdata == {23'h0, pll_a_fraction[8:0]}) else $error("stored read wrong");
	a_rev_read: assert property (s_rd(6'h02) |-> prdata == {23'h0, REVISION})
		else $error("revision read wrong");
	a_frac_hold: assert property (!(psel && penable && pwrite) |=> $stable(pll_a_fraction))
		else $error("fraction moved without write");
	a_soft_reset: assert property (s_wr(6'h35) |=> pll_a_fraction == 22'h36FD21)
		else $error("soft reset missed fraction");
	a_rx_divider: assert property (receiver_clock_mode |->
		pll_a_output_divider == rx_auto_divider) else $error("divider not automatic");
	a_fs_select: assert property (pll_a_clock_256fs ==
		(receiver_clock_mode && !pll_a_output_scaler)) else $error("fs select wrong");
	a_halver_flag: assert property (halver_mismatch == (receiver_clock_mode &&
		pll_a_input_halver != pll_b_input_halver)) else $error("halver flag wrong");
	a_rb_reset: assert property ($rose(presetn) |-> !readback_enable &&
		!continuous_readback && readback_source_select == 3'h0) else $error("readback reset");
	a_unmapped_err: assert property (psel && penable &&
		paddr[7:2] inside {[6'h04:6'h22], [6'h37:6'h3F]} |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
endmodule : codec_register_map_pll_a_cfg_props

bind codec_register_map_pll_a_cfg codec_register_map_pll_a_cfg_props #(
	.IDENT_LOW(IDENT_LOW), .REVISION(REVISION)) u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .rx_auto_divider, .pll_a_fraction,
	.pll_a_input_halver, .pll_a_output_scaler, .pll_a_output_divider, .pll_a_clock_256fs,
	.receiver_clock_mode, .pll_b_input_halver, .halver_mismatch, .readback_enable,
	.continuous_readback, .readback_source_select);

// ---- codec_register_map_pll_a_cfg_tb.sv ----
// Purpose: self-checking bench for the codec register bank
// Assumes: apb slave answers when pready is high
// Notes: status words are fixed distinct patterns
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module codec_register_map_pll_a_cfg_tb;
	import codec_regs_pkg::*;
	// identity values, arbitrary
	localparam logic [8:0] ID_LO = 9'h0A5;
	localparam logic [8:0] ID_HI = 9'h05A;
	localparam logic [8:0] REV = 9'h003;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e_r;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	status_t status = {9'h101, 9'h0A2, 9'h143, 9'h0E4, 9'h185, 9'h026, 9'h1C7};
	logic [1:0] rx_auto_divider = 2'h1, pll_a_output_divider, pll_b_output_divider;
	config_t cfg;
	logic [21:0] pll_a_fraction;
	logic [3:0] pll_a_integer;
	logic pll_a_integer_out_of_range, pll_a_input_halver, pll_a_clock_256fs, halver_mismatch;
	logic pll_b_post_used, readback_enable, continuous_readback, pll_b_output_scaler;
	logic [2:0] readback_source_select;
	int errors = 0, n_tests = 0;
	logic [5:0] ri [13] = '{6'h03, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2A,
		6'h32, 6'h33, 6'h34, 6'h36};
	logic [8:0] rv [13] = '{9'h010, 9'h00B, 9'h039, 9'h000, 9'h010, 9'h032, 9'h054, 9'h076,
		9'h098, 9'h07E, 9'h03E, 9'h000, 9'h010};
	codec_register_map_pll_a_cfg #(.IDENT_LOW(ID_LO), .IDENT_HIGH(ID_HI), .REVISION(REV))
		u_codec_register_map_pll_a_cfg (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .status, .rx_auto_divider, .cfg,
		.pll_a_fraction, .pll_a_integer, .pll_a_integer_out_of_range, .pll_a_input_halver,
		.pll_a_output_scaler(), .pll_a_output_divider, .pll_a_clock_256fs,
		.receiver_clock_mode(), .pll_b_input_halver(), .pll_b_output_scaler,
		.pll_b_output_divider, .pll_b_post_used, .halver_mismatch, .readback_enable,
		.continuous_readback, .readback_source_select);
	//------------------------------------------------------------
	// clock, watchdog and closing
	//------------------------------------------------------------
	initial
	begin
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		#100us;
		errors++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		if (errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	//------------------------------------------------------------
	// apb master
	//------------------------------------------------------------
	// called just after a rising edge; setup, then access held until pready
	task automatic apb(input logic w, input logic [5:0] i, input logic [8:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {23'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e_r = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [5:0] i, input logic [8:0] e);
		apb(1'b0, i, 9'h000);
		`CHK(r, {23'h0, e})
	endtask : rd
	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_defaults();
		for (int k = 0; k < 13; k++)
			rd(ri[k], rv[k]);
		`CHK(pll_a_fraction, 22'h36FD21)
		`CHK(cfg, {9'h00B, 9'h039, 9'h000, 9'h010, 9'h032, 9'h054, 9'h076, 9'h07E, 9'h03E})
		`CHK(readback_enable, 1'b0)
	endtask : t_defaults
	task automatic t_ident();
		apb(1'b1, 6'h00, 9'h0F0);
		apb(1'b1, 6'h01, 9'h10F);
		apb(1'b1, 6'h02, 9'h0D5);
		`CHK(pll_a_fraction, {4'h5, 9'h10F, 9'h0F0})
		`CHK({pll_a_integer, pll_a_integer_out_of_range}, 5'h1A)
		rd(6'h00, ID_LO);
		rd(6'h01, ID_HI);
		rd(6'h02, REV);
		apb(1'b1, 6'h02, 9'h045);
		`CHK(pll_a_integer_out_of_range, 1'b1)
	endtask : t_ident
	task automatic t_continuous_readback();
		apb(1'b1, 6'h34, 9'h008);
		`CHK(continuous_readback, 1'b1)
		rd(6'h00, 9'h0F0);
		rd(6'h01, 9'h10F);
		rd(6'h02, REV);
		apb(1'b1, 6'h34, 9'h015);
		`CHK({readback_enable, continuous_readback, readback_source_select}, 5'h15)
		rd(6'h00, ID_LO);
	endtask : t_continuous_readback
	task automatic t_rxmode();
		apb(1'b1, 6'h03, 9'h001);
		apb(1'b1, 6'h36, 9'h001);
		`CHK({pll_a_input_halver, halver_mismatch, pll_a_clock_256fs}, 3'h7)
		`CHK(pll_a_output_divider, 2'h1)
		rx_auto_divider <= 2'h2;
		apb(1'b1, 6'h36, 9'h003);
		`CHK({halver_mismatch, pll_a_output_divider, pll_b_post_used}, 4'h4)
		apb(1'b1, 6'h03, 9'h01B);
		`CHK(pll_a_clock_256fs, 1'b0)
		apb(1'b1, 6'h36, 9'h01C);
		`CHK({pll_a_output_divider, pll_b_post_used}, 3'h7)
		`CHK({pll_b_output_scaler, pll_b_output_divider}, 3'h7)
	endtask : t_rxmode
	task automatic t_status();
		for (int k = 0; k < 7; k++)
		begin
			apb(1'b1, 6'h2B + 6'(k), 9'h1FF);
			rd(6'h2B + 6'(k), status[62 - 9 * k -: 9]);
		end
		apb(1'b1, 6'h2A, 9'h1FF);
		rd(6'h2A, 9'h098);
		`CHK(e_r, 1'b0)
		rd(6'h10, 9'h000);
		`CHK(e_r, 1'b1)
		apb(1'b1, 6'h3F, 9'h1FF);
		`CHK(e_r, 1'b1)
	endtask : t_status
	task automatic t_swreset();
		for (int k = 0; k < 13; k++)
			apb(1'b1, ri[k], 9'h1FF);
		apb(1'b1, 6'h02, 9'h1FF);
		apb(1'b1, 6'h35, 9'h000);
		rd(6'h35, 9'h000);
		t_defaults();
	endtask : t_swreset
	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_defaults();
		t_ident();
		t_continuous_readback();
		t_rxmode();
		t_status();
		t_swreset();
		tally_and_finish();
	end
endmodule : codec_register_map_pll_a_cfg_tb
